// >>> logic/crr_pkg.sv
// Package for the calibration and reference register bank.
// Assumes byte-wide registers on a plain strobe port, 24-bit samples.
package crr_pkg;
  localparam logic [7:0] ADDR_REF      = 8'h06;
  localparam logic [7:0] ADDR_OFS_LO   = 8'h07;
  localparam logic [7:0] ADDR_OFS_MID  = 8'h08;
  localparam logic [7:0] ADDR_OFS_HI   = 8'h09;
  localparam logic [7:0] ADDR_GAIN_LO  = 8'h0A;
  localparam logic [7:0] ADDR_GAIN_MID = 8'h0B;
  localparam logic [7:0] ADDR_GAIN_HI  = 8'h0C;
  localparam logic [7:0] ADDR_RSV_A    = 8'h0D;
  localparam logic [7:0] ADDR_RSV_B    = 8'h0E;
  localparam logic [7:0] ADDR_RSV_C    = 8'h0F;
  localparam logic [7:0] RST_REF       = 8'h05;
  localparam logic [7:0] RST_OFS       = 8'h00;
  localparam logic [7:0] RST_GAIN_LO   = 8'h00;
  localparam logic [7:0] RST_GAIN_MID  = 8'h00;
  localparam logic [7:0] RST_GAIN_HI   = 8'h40;
  localparam logic [7:0] RSV_A_VALUE   = 8'hFF;
  localparam logic [7:0] RSV_ZERO      = 8'h00;
  localparam int         REFP_LSB      = 2;
  localparam int         REFN_LSB      = 0;
  localparam int         GAIN_SHIFT    = 22;
  localparam logic signed [23:0] SAT_MAX = 24'sh7FFFFF;
  localparam logic signed [23:0] SAT_MIN = -24'sh800000;

  typedef enum logic [1:0] {
    REF_RESERVED = 2'b00,
    REF_SUPPLY   = 2'b01,
    REF_PIN      = 2'b10,
    REF_AIN      = 2'b11
  } crr_ref_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } crr_bus_s;

  typedef struct packed {
    logic              valid;
    logic signed [23:0] data;
  } crr_sample_s;

  // One-hot source selection
  typedef struct packed {
    logic supply;
    logic pin;
    logic ain;
  } crr_src_s;
endpackage

// >>> logic/crr_top.sv
// Calibration and reference register bank with offset/gain correction.
// Assumes raw samples synchronous to CLOCK_I and a master that never waits.
`timescale 1ns/1ps
//
// Contract
// - Decode positive reference selector bits 3:2
// - Decode negative reference selector bits 1:0
// - Reference register at 06h, resets 05h
// - Offset word from bytes 07h-09h, LSB low
// - Offset word is signed two's complement
// - Subtract offset first, then apply gain
// - Offset bytes reset to 00h
// - Unsigned gain word from bytes 0Ah-0Ch
// - Scale by gain word over 400000h
// - Gain bytes reset 00h, 00h, 40h
// - 0Dh read-only, ignores writes, reads FFh
// - 0Eh, 0Fh read-only, read zero
module crr_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RSTN_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic        RAW_VALID_I,
  input  wire logic [23:0] RAW_DATA_I,
  output logic      [7:0]  RDATA_O,
  output logic             COR_VALID_O,
  output logic      [23:0] COR_DATA_O,
  output logic      [2:0]  REFP_SRC_O,
  output logic      [2:0]  REFN_SRC_O
);
  crr_pkg::crr_bus_s    bus;
  crr_pkg::crr_sample_s raw;
  logic [7:0]  ref_q;
  logic [7:0]  ofs_q [3];
  logic [7:0]  gain_q [3];
  logic signed [23:0] offset_word;
  logic        [23:0] gain_word;
  logic signed [24:0] diff_d;
  logic signed [24:0] diff_q;
  logic               diff_vld_q;
  logic signed [49:0] prod;
  logic signed [27:0] scaled;
  logic signed [23:0] cor_d;
  crr_pkg::crr_src_s  refp_d;
  crr_pkg::crr_src_s  refn_d;

  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign raw = '{valid: RAW_VALID_I, data: RAW_DATA_I};

  // Reserved selector code leaves every source disconnected
  function automatic crr_pkg::crr_src_s dec_ref(input logic [1:0] sel);
    crr_pkg::crr_src_s s;
    s = '0;
    case (sel)
      crr_pkg::REF_SUPPLY: s.supply = 1'b1;
      crr_pkg::REF_PIN:    s.pin    = 1'b1;
      crr_pkg::REF_AIN:    s.ain    = 1'b1;
      default:             s        = '0;
    endcase
    return s;
  endfunction

  // Register writes
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ref_q     <= crr_pkg::RST_REF;
      ofs_q[0]  <= crr_pkg::RST_OFS;
      ofs_q[1]  <= crr_pkg::RST_OFS;
      ofs_q[2]  <= crr_pkg::RST_OFS;
      gain_q[0] <= crr_pkg::RST_GAIN_LO;
      gain_q[1] <= crr_pkg::RST_GAIN_MID;
      gain_q[2] <= crr_pkg::RST_GAIN_HI;
    end else if (bus.wr) begin
      // Reserved bytes have no storage, so writes there fall away
      case (bus.addr)
        crr_pkg::ADDR_REF:      ref_q     <= bus.wdata;
        crr_pkg::ADDR_OFS_LO:   ofs_q[0]  <= bus.wdata;
        crr_pkg::ADDR_OFS_MID:  ofs_q[1]  <= bus.wdata;
        crr_pkg::ADDR_OFS_HI:   ofs_q[2]  <= bus.wdata;
        crr_pkg::ADDR_GAIN_LO:  gain_q[0] <= bus.wdata;
        crr_pkg::ADDR_GAIN_MID: gain_q[1] <= bus.wdata;
        crr_pkg::ADDR_GAIN_HI:  gain_q[2] <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        crr_pkg::ADDR_REF:      RDATA_O <= ref_q;
        crr_pkg::ADDR_OFS_LO:   RDATA_O <= ofs_q[0];
        crr_pkg::ADDR_OFS_MID:  RDATA_O <= ofs_q[1];
        crr_pkg::ADDR_OFS_HI:   RDATA_O <= ofs_q[2];
        crr_pkg::ADDR_GAIN_LO:  RDATA_O <= gain_q[0];
        crr_pkg::ADDR_GAIN_MID: RDATA_O <= gain_q[1];
        crr_pkg::ADDR_GAIN_HI:  RDATA_O <= gain_q[2];
        crr_pkg::ADDR_RSV_A:    RDATA_O <= crr_pkg::RSV_A_VALUE;
        crr_pkg::ADDR_RSV_B:    RDATA_O <= crr_pkg::RSV_ZERO;
        crr_pkg::ADDR_RSV_C:    RDATA_O <= crr_pkg::RSV_ZERO;
        default:                RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // Reference source decode
  assign refp_d = dec_ref(ref_q[crr_pkg::REFP_LSB +: 2]);
  assign refn_d = dec_ref(ref_q[crr_pkg::REFN_LSB +: 2]);

  // Registered so each source switches one clock after the write lands
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REFP_SRC_O <= 3'h4;
      REFN_SRC_O <= 3'h4;
    end else begin
      REFP_SRC_O <= refp_d;
      REFN_SRC_O <= refn_d;
    end
  end

  assign offset_word = $signed({ofs_q[2], ofs_q[1], ofs_q[0]});
  assign gain_word   = {gain_q[2], gain_q[1], gain_q[0]};

  // Stage 1: offset removal, one guard bit so nothing wraps
  assign diff_d = 25'(raw.data) - 25'(offset_word);

  // Offset is read as the sample is taken; a byte written mid-stream applies at once
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      diff_q     <= '0;
      diff_vld_q <= 1'b0;
    end else begin
      diff_vld_q <= raw.valid;
      if (raw.valid) begin
        diff_q <= diff_d;
      end
    end
  end

  // Stage 2: gain on the corrected value, flooring divide by 2^22 (arithmetic shift)
  assign prod   = 50'(diff_q) * $signed({1'b0, gain_word});
  assign scaled = 28'(prod >>> crr_pkg::GAIN_SHIFT);

  always_comb begin
    // Product spans 27 bits after the shift at full-scale gain
    // Clip rather than wrap: a wrapped value flips sign on overload
    if (scaled > 28'(crr_pkg::SAT_MAX)) begin
      cor_d = crr_pkg::SAT_MAX;
    end else if (scaled < 28'(crr_pkg::SAT_MIN)) begin
      cor_d = crr_pkg::SAT_MIN;
    end else begin
      cor_d = scaled[23:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      COR_VALID_O <= 1'b0;
      COR_DATA_O  <= 24'h000000;
    end else begin
      COR_VALID_O <= diff_vld_q;
      if (diff_vld_q) begin
        COR_DATA_O <= cor_d;
      end
    end
  end

  // Checks
  // Properties look only at what the design drives
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  logic unity_gain;
  logic zero_ofs;
  assign unity_gain = (gain_word == 24'h400000);
  assign zero_ofs   = (offset_word == 24'sh000000);

  ref_reset_a: assert property ($rose(RSTN_I) |-> ref_q == crr_pkg::RST_REF)
    else $error("reference register not at reset value");
  ofs_reset_a: assert property (
    $rose(RSTN_I) |-> offset_word == 24'sh000000)
    else $error("offset word not cleared by reset");
  gain_reset_a: assert property (
    $rose(RSTN_I) |-> gain_word == 24'h400000)
    else $error("gain word not at unity after reset");

  // One source per selector code, none for the reserved code
  refp_dec_a: assert property (
    ref_q[3:2] == 2'b11 |=> REFP_SRC_O == 3'b001)
    else $error("positive reference decode wrong");
  refp_supply_a: assert property (
    ref_q[3:2] == 2'b01 |=> REFP_SRC_O == 3'b100)
    else $error("positive supply reference not selected");
  refp_pin_a: assert property (
    ref_q[3:2] == 2'b10 |=> REFP_SRC_O == 3'b010)
    else $error("positive reference pin not selected");
  refp_rsvd_a: assert property (
    ref_q[3:2] == 2'b00 |=> REFP_SRC_O == 3'b000)
    else $error("reserved positive code selected a source");
  refn_dec_a: assert property (
    ref_q[1:0] == 2'b10 |=> REFN_SRC_O == 3'b010)
    else $error("negative reference decode wrong");
  refn_supply_a: assert property (
    ref_q[1:0] == 2'b01 |=> REFN_SRC_O == 3'b100)
    else $error("negative supply reference not selected");
  refn_ain_a: assert property (
    ref_q[1:0] == 2'b11 |=> REFN_SRC_O == 3'b001)
    else $error("second negative input not selected");
  refn_rsvd_a: assert property (
    ref_q[1:0] == 2'b00 |=> REFN_SRC_O == 3'b000)
    else $error("reserved negative code selected a source");

  // Read data is the register as it stood at the strobe edge
  ref_rd_a: assert property (
    bus.rd && bus.addr == crr_pkg::ADDR_REF |=> RDATA_O == $past(ref_q))
    else $error("reference register read wrong");
  rsv_a_read_a: assert property (
    bus.rd && bus.addr == crr_pkg::ADDR_RSV_A |=> RDATA_O == 8'hFF)
    else $error("reserved byte 0Dh read wrong");
  rsv_zero_read_a: assert property (
    bus.rd && (bus.addr == crr_pkg::ADDR_RSV_B || bus.addr == crr_pkg::ADDR_RSV_C)
    |=> RDATA_O == 8'h00)
    else $error("reserved byte read nonzero");

  // Each byte lands alone; there is no shadow copy of the whole word
  ofs_lo_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_OFS_LO
    |=> offset_word[7:0] == $past(bus.wdata))
    else $error("offset low byte not stored");
  ofs_mid_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_OFS_MID
    |=> offset_word[15:8] == $past(bus.wdata))
    else $error("offset middle byte not stored");
  ofs_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_OFS_HI
    |=> offset_word[23:16] == $past(bus.wdata))
    else $error("offset high byte not stored");
  gain_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_GAIN_LO
    |=> gain_word[7:0] == $past(bus.wdata))
    else $error("gain low byte not stored");
  gain_mid_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_GAIN_MID
    |=> gain_word[15:8] == $past(bus.wdata))
    else $error("gain middle byte not stored");
  gain_hi_write_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_GAIN_HI
    |=> gain_word[23:16] == $past(bus.wdata))
    else $error("gain high byte not stored");

  // Writes to 0Eh and 0Fh leave every register as it was; a write to 0Dh still reads back FFh
  rsv_keep_a: assert property (
    bus.wr && (bus.addr == crr_pkg::ADDR_RSV_B || bus.addr == crr_pkg::ADDR_RSV_C)
    |=> {ref_q, offset_word, gain_word} == $past({ref_q, offset_word, gain_word}))
    else $error("reserved byte write changed a register");
  rsv_wr_a: assert property (
    bus.wr && bus.addr == crr_pkg::ADDR_RSV_A ##1 bus.rd && bus.addr == crr_pkg::ADDR_RSV_A
    |=> RDATA_O == 8'hFF)
    else $error("reserved byte took a write");

  // Two registered stages between a raw sample and its answer
  cor_valid_a: assert property (
    COR_VALID_O == $past(raw.valid, 2))
    else $error("corrected sample not two cycles after raw");

  // Worked cases with known answers; gain must hold for the second stage
  unity_pass_a: assert property (
    raw.valid && zero_ofs && unity_gain ##1 unity_gain
    |=> COR_VALID_O && COR_DATA_O == $past(raw.data, 2))
    else $error("unity gain changed sample");
  ofs_sub_a: assert property (
    raw.valid && unity_gain && offset_word == 24'sh000001 && raw.data == 24'h000005
    ##1 unity_gain |=> COR_DATA_O == 24'h000004)
    else $error("offset not subtracted");
  neg_ofs_a: assert property (
    raw.valid && unity_gain && offset_word == -24'sh000001 && raw.data == 24'h000000
    ##1 unity_gain |=> COR_DATA_O == 24'h000001)
    else $error("offset not signed");
  gain_half_a: assert property (
    raw.valid && gain_word == 24'h200000 && offset_word == -24'sh000002
    && raw.data == 24'h000005 ##1 gain_word == 24'h200000 |=> COR_DATA_O == 24'h000003)
    else $error("half gain not applied after offset");
  clip_a: assert property (
    raw.valid && unity_gain && offset_word == -24'sh000001 && raw.data == 24'h7FFFFF
    ##1 unity_gain |=> COR_DATA_O == 24'h7FFFFF)
    else $error("overflow not clipped");
  clip_low_a: assert property (
    raw.valid && unity_gain && offset_word == 24'sh000001 && raw.data == 24'h800000
    ##1 unity_gain |=> COR_DATA_O == 24'h800000)
    else $error("underflow not clipped");

  // Main scenarios
  cov_sample_c: cover property (raw.valid ##2 COR_VALID_O);
  cov_clip_c: cover property (diff_vld_q && scaled > 28'(crr_pkg::SAT_MAX));
  cov_neg_clip_c: cover property (diff_vld_q && scaled < 28'(crr_pkg::SAT_MIN));
  cov_gain_wr_c: cover property (bus.wr && bus.addr == crr_pkg::ADDR_GAIN_HI);
  cov_ref_rd_c: cover property (bus.rd && bus.addr == crr_pkg::ADDR_REF);
endmodule

// >>> bench/crr_top_tb.sv
// Self-checking bench for the calibration and reference register bank.
// Assumes crr_top with registered read data and a two-cycle sample path.
`timescale 1ns/1ps
module crr_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        raw_v = 1'b0;
  logic [23:0] raw_d = 24'h000000;
  logic [7:0]  rdata;
  logic        cor_v;
  logic [23:0] cor_d;
  logic [2:0]  refp;
  logic [2:0]  refn;
  int          bad_count = 0;
  int          samples_checked = 0;

  crr_top dut (.CLOCK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RAW_VALID_I(raw_v), .RAW_DATA_I(raw_d), .RDATA_O(rdata), .COR_VALID_O(cor_v),
    .COR_DATA_O(cor_d), .REFP_SRC_O(refp), .REFN_SRC_O(refn));

  always #4 clk = ~clk;

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("rdata@%h", a), {16'h0000, rdata}, {16'h0000, exp});
  endtask

  task automatic sample(input logic [23:0] d, input logic [23:0] exp);
    @(posedge clk);
    raw_v <= 1'b1;
    raw_d <= d;
    @(posedge clk);
    raw_v <= 1'b0;
    @(posedge clk);
    #1;
    chk("cor_valid", {23'h0, cor_v}, 24'h000001);
    chk("cor_data", cor_d, exp);
  endtask

  task automatic test_reset_values;
    chk("refp", {21'h0, refp}, 24'h000004);
    chk("refn", {21'h0, refn}, 24'h000004);
    rd_chk(8'h06, 8'h05);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h0A, 8'h00);
    rd_chk(8'h0B, 8'h00);
    rd_chk(8'h0C, 8'h40);
    sample(24'h123456, 24'h123456);
    $display("test reset values done");
  endtask

  task automatic test_ref_decode;
    logic [2:0] exp;
    for (int c = 0; c < 4; c++) begin
      exp = (c == 0) ? 3'b000 : 3'(3'b001 << (3 - c));
      wr_reg(8'h06, {4'h0, 2'(c), 2'(3 - c)});
      @(posedge clk);
      #1;
      chk("refp", {21'h0, refp}, {21'h0, exp});
      chk("refn", {21'h0, refn}, {21'h0, ((3 - c) == 0) ? 3'b000 : 3'(3'b001 << c)});
      rd_chk(8'h06, {4'h0, 2'(c), 2'(3 - c)});
    end
    $display("test reference decode done");
  endtask

  task automatic test_reserved;
    wr_reg(8'h0D, 8'h5A);
    wr_reg(8'h0E, 8'h5A);
    wr_reg(8'h0F, 8'h5A);
    wr_reg(8'h20, 8'h5A);
    // Write then read with no gap: the dropped write must not show
    @(posedge clk);
    wr <= 1'b1;
    addr <= 8'h0D;
    wdata <= 8'hA5;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata@0d back to back", {16'h0000, rdata}, 24'h0000FF);
    @(posedge clk);
    #1;
    chk("rdata after read", {16'h0000, rdata}, 24'h000000);
    rd_chk(8'h0D, 8'hFF);
    rd_chk(8'h0E, 8'h00);
    rd_chk(8'h0F, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test reserved bytes done");
  endtask

  task automatic test_correction;
    // Offset -2 then half gain: order of the two steps changes the answer
    wr_reg(8'h07, 8'hFE);
    wr_reg(8'h08, 8'hFF);
    wr_reg(8'h09, 8'hFF);
    rd_chk(8'h08, 8'hFF);
    sample(24'h000005, 24'h000007);
    wr_reg(8'h0C, 8'h20);
    sample(24'h000005, 24'h000003);
    wr_reg(8'h0A, 8'h01);
    sample(24'hFFFFF0, 24'hFFFFF8);
    wr_reg(8'h0B, 8'h5A);
    rd_chk(8'h0B, 8'h5A);
    wr_reg(8'h07, 8'h01);
    wr_reg(8'h08, 8'h00);
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h0A, 8'h00);
    wr_reg(8'h0B, 8'h00);
    wr_reg(8'h0C, 8'h40);
    sample(24'h000005, 24'h000004);
    sample(24'h800000, 24'h800000);
    // Offset -1: sign of the offset word and clipping at the top
    wr_reg(8'h07, 8'hFF);
    wr_reg(8'h08, 8'hFF);
    wr_reg(8'h09, 8'hFF);
    sample(24'h000000, 24'h000001);
    sample(24'h7FFFFF, 24'h7FFFFF);
    wr_reg(8'h0C, 8'h80);
    sample(24'h7FFFFF, 24'h7FFFFF);
    $display("test correction done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_ref_decode();
    test_reserved();
    test_correction();
    close_out();
  end

  // About 125 cycles of traffic; the limit leaves wide margin
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
